// [rtl/pbd_pkg.sv]
package pbd_pkg;
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] PBD_ADDR_PORTB_CTRL = 8'h00;
	localparam logic [7:0] PBD_ADDR_PORTD_CTRL = 8'h04;
	localparam logic [7:0] PBD_ADDR_PORTB_DATA = 8'h08;
	localparam logic [7:0] PBD_ADDR_PORTD_DATA = 8'h0c;
	localparam logic [7:0] PBD_ADDR_PORTB_PINS = 8'h10;
	localparam logic [7:0] PBD_ADDR_PORTD_PINS = 8'h14;
	localparam logic [7:0] PBD_ADDR_STATUS = 8'h18;

	// ----------------------------------------
	// Widths and reset values
	// ----------------------------------------
	localparam int PBD_PORTB_PINS = 8;
	localparam int PBD_PORTD_PINS = 6;
	localparam logic [15:0] PBD_PORTB_CTRL_RST = 16'h000a;
	localparam logic [15:0] PBD_PORTD_CTRL_RST = 16'h0000;
	localparam logic [15:0] PBD_PORTD_CTRL_MASK = 16'h0fff;
	localparam logic [7:0] PBD_PORTB_DATA_RST = 8'h00;
	localparam logic [5:0] PBD_PORTD_DATA_RST = 6'h00;

	// ----------------------------------------
	// Mode codes
	// ----------------------------------------
	localparam logic [1:0] PBD_MODE_PERIPH = 2'h0;
	localparam logic [1:0] PBD_MODE_OUT = 2'h1;
	localparam logic [1:0] PBD_MODE_IN_PU = 2'h2;
	localparam logic [1:0] PBD_MODE_IN_NOPU = 2'h3;
endpackage : pbd_pkg

// [rtl/pbd_pin_cell.sv]
`timescale 1ns/1ps
`default_nettype none
module pbd_pin_cell
	import pbd_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic [1:0] mode,
	input wire logic port_data,
	input wire logic periph_out,
	input wire logic periph_oe,
	input wire logic pin_in,
	output logic pin_out,
	output logic pin_oe,
	output logic pin_pullup,
	output logic pin_level,
	output logic periph_in
);
	logic [2:0] sync_reg;

	// ----------------------------------------
	// Pin input synchroniser and filter
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			sync_reg <= 3'h0;
		else if (clk_en)
			sync_reg <= {sync_reg[1:0], pin_in};
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pin_level <= 1'b0;
		else if (clk_en && (sync_reg[1] == sync_reg[2]))
			pin_level <= sync_reg[2];
	end

	// ----------------------------------------
	// Mode routing
	// ----------------------------------------
	always_comb
	begin
		pin_out = 1'b0;
		pin_oe = 1'b0;
		pin_pullup = 1'b0;
		periph_in = 1'b0;
		case (mode)
			PBD_MODE_PERIPH:
			begin
				pin_out = periph_out;
				pin_oe = periph_oe;
				periph_in = pin_level;
			end
			PBD_MODE_OUT:
			begin
				pin_out = port_data;
				pin_oe = 1'b1;
			end
			PBD_MODE_IN_PU:
				pin_pullup = 1'b1;
			default:
				pin_pullup = 1'b0;
		endcase
	end
endmodule : pbd_pin_cell
`default_nettype wire

// [rtl/pbd_top.sv]
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module pbd_top
	import pbd_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic manual_resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] portb_in,
	output logic [7:0] portb_out,
	output logic [7:0] portb_oe,
	output logic [7:0] portb_pullup,
	input wire logic [7:0] portb_periph_out,
	input wire logic [7:0] portb_periph_oe,
	output logic [7:0] portb_periph_in,
	input wire logic [5:0] portd_in,
	output logic [5:0] portd_out,
	output logic [5:0] portd_oe,
	output logic [5:0] portd_pullup,
	input wire logic [5:0] portd_periph_out,
	input wire logic [5:0] portd_periph_oe,
	output logic [5:0] portd_periph_in
);
	logic [15:0] portb_ctrl_reg;
	logic [15:0] portd_ctrl_reg;
	logic [7:0] portb_data_reg;
	logic [5:0] portd_data_reg;
	logic [7:0] portb_level;
	logic [5:0] portd_level;
	logic [2:0] mres_sync_reg;
	logic manual_reset_active;
	logic wr_en;
	logic rd_en;
	logic [31:0] prdata_next;
	logic addr_ok;

	// ----------------------------------------
	// Field layout
	// ----------------------------------------
	localparam int PBD_FIELD_W = 2;
	localparam logic [2:0] PBD_MRES_IDLE = 3'h7;

	function automatic int pbd_field_lsb(input int pin);
		return pin * PBD_FIELD_W;
	endfunction : pbd_field_lsb

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [15:0] pbd_merge16(input logic [15:0] old_val,
		input logic [31:0] wdata, input logic [3:0] strb);
		logic [15:0] res;
		res = old_val;
		if (strb[0])
			res[7:0] = wdata[7:0];
		if (strb[1])
			res[15:8] = wdata[15:8];
		return res;
	endfunction : pbd_merge16

	// ----------------------------------------
	// Manual reset synchroniser
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			mres_sync_reg <= PBD_MRES_IDLE;
		else if (clk_en)
			mres_sync_reg <= {mres_sync_reg[1:0], manual_resetn};
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			manual_reset_active <= 1'b0;
		else if (clk_en && (mres_sync_reg[1] == mres_sync_reg[2]))
			manual_reset_active <= !mres_sync_reg[2];
	end

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	// Zero wait states: every access ends in its first access cycle
	assign pready = 1'b1;
	assign wr_en = psel && penable && pwrite && clk_en;
	assign rd_en = psel && !penable && !pwrite;

	always_comb
	begin
		addr_ok = 1'b1;
		prdata_next = 32'h0;
		if (paddr == PBD_ADDR_PORTB_CTRL)
			prdata_next[15:0] = portb_ctrl_reg;
		else if (paddr == PBD_ADDR_PORTD_CTRL)
			prdata_next[15:0] = portd_ctrl_reg & PBD_PORTD_CTRL_MASK;
		else if (paddr == PBD_ADDR_PORTB_DATA)
			prdata_next[7:0] = portb_data_reg;
		else if (paddr == PBD_ADDR_PORTD_DATA)
			prdata_next[5:0] = portd_data_reg;
		else if (paddr == PBD_ADDR_PORTB_PINS)
			prdata_next[7:0] = portb_level;
		else if (paddr == PBD_ADDR_PORTD_PINS)
			prdata_next[5:0] = portd_level;
		else if (paddr == PBD_ADDR_STATUS)
			prdata_next[0] = manual_reset_active;
		else
			addr_ok = 1'b0;
	end

	assign pslverr = psel && penable && !addr_ok;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0;
		else if (clk_en && rd_en)
			prdata <= prdata_next;
	end

	// ----------------------------------------
	// Control registers, untouched by manual reset
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			portb_ctrl_reg <= PBD_PORTB_CTRL_RST;
		else if (wr_en && paddr == PBD_ADDR_PORTB_CTRL)
			portb_ctrl_reg <= pbd_merge16(portb_ctrl_reg, pwdata, pstrb);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			portd_ctrl_reg <= PBD_PORTD_CTRL_RST;
		else if (wr_en && paddr == PBD_ADDR_PORTD_CTRL)
			portd_ctrl_reg <= pbd_merge16(portd_ctrl_reg, pwdata, pstrb)
				& PBD_PORTD_CTRL_MASK;
	end

	// ----------------------------------------
	// Port data registers
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			portb_data_reg <= PBD_PORTB_DATA_RST;
		else if (wr_en && paddr == PBD_ADDR_PORTB_DATA && pstrb[0])
			portb_data_reg <= pwdata[7:0];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			portd_data_reg <= PBD_PORTD_DATA_RST;
		else if (wr_en && paddr == PBD_ADDR_PORTD_DATA && pstrb[0])
			portd_data_reg <= pwdata[5:0];
	end

	// ----------------------------------------
	// Pin cells
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < PBD_PORTB_PINS; gi++)
		begin : g_portb
			pbd_pin_cell u_cell (
				.pclk(pclk),
				.presetn(presetn),
				.clk_en(clk_en),
				.mode(portb_ctrl_reg[pbd_field_lsb(gi) +: PBD_FIELD_W]),
				.port_data(portb_data_reg[gi]),
				.periph_out(portb_periph_out[gi]),
				.periph_oe(portb_periph_oe[gi]),
				.pin_in(portb_in[gi]),
				.pin_out(portb_out[gi]),
				.pin_oe(portb_oe[gi]),
				.pin_pullup(portb_pullup[gi]),
				.pin_level(portb_level[gi]),
				.periph_in(portb_periph_in[gi])
			);
		end
		for (gi = 0; gi < PBD_PORTD_PINS; gi++)
		begin : g_portd
			pbd_pin_cell u_cell (
				.pclk(pclk),
				.presetn(presetn),
				.clk_en(clk_en),
				.mode(portd_ctrl_reg[pbd_field_lsb(gi) +: PBD_FIELD_W]),
				.port_data(portd_data_reg[gi]),
				.periph_out(portd_periph_out[gi]),
				.periph_oe(portd_periph_oe[gi]),
				.pin_in(portd_in[gi]),
				.pin_out(portd_out[gi]),
				.pin_oe(portd_oe[gi]),
				.pin_pullup(portd_pullup[gi]),
				.pin_level(portd_level[gi]),
				.periph_in(portd_periph_in[gi])
			);
		end
	endgenerate
endmodule : pbd_top
`default_nettype wire

// [test/pbd_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module pbd_asserts (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic manual_resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [7:0] portb_oe,
	input wire logic [7:0] portb_pullup,
	input wire logic [7:0] portb_periph_oe,
	input wire logic [7:0] portb_periph_in,
	input wire logic [5:0] portd_oe,
	input wire logic [5:0] portd_pullup,
	input wire logic [5:0] portd_periph_oe,
	input wire logic [5:0] portd_periph_in
);
	// ----------------------------------------
	// Shadow of both control registers
	// ----------------------------------------
	logic [15:0] sb_reg;
	logic [11:0] sd_reg;
	logic [27:0] m;
	logic [13:0] pu, oe, m0;
	wire logic wr = psel && penable && pwrite && clk_en;
	wire logic rd = psel && penable && !pwrite;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			sb_reg <= 16'h000a;
			sd_reg <= 12'h000;
		end
		else if (wr && paddr == 8'h00)
			sb_reg <= pwdata[15:0];
		else if (wr && paddr == 8'h04)
			sd_reg <= pwdata[11:0];
	assign m = {sd_reg, sb_reg};
	always_comb
		for (int i = 0; i < 14; i++)
		begin
			m0[i] = m[2*i+:2] == 2'h0;
			pu[i] = m[2*i+:2] == 2'h2;
			oe[i] = m[2*i+:2] == 2'h1;
		end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_pullup_mode: assert property (
		{portd_pullup, portb_pullup} == pu) else $error("pullup mismatch");
	chk_drive_mode: assert property (
		{portd_oe, portb_oe} == (oe | (m0 & {portd_periph_oe, portb_periph_oe})))
		else $error("drive enable mismatch");
	chk_periph_gate: assert property (
		({portd_periph_in, portb_periph_in} & ~m0) == 14'h0) else $error("periph in leak");
	chk_pb_readback: assert property (
		rd && paddr == 8'h00 |-> prdata[15:0] == sb_reg) else $error("port b readback");
	chk_pb_upper: assert property (
		rd && paddr == 8'h00 |-> prdata[31:16] == 16'h0) else $error("port b upper bits");
	chk_pd_readback: assert property (
		rd && paddr == 8'h04 |-> prdata[11:0] == sd_reg) else $error("port d readback");
	chk_pd_reserved: assert property (
		rd && paddr == 8'h04 |-> prdata[31:12] == 20'h0) else $error("port d reserved");
	chk_manual_hold: assert property (
		!manual_resetn && !wr |=> $stable({portd_pullup, portb_pullup}))
		else $error("manual reset changed modes");
	chk_ready_access: assert property (
		psel && penable |-> pready) else $error("ready low in access");
	chk_error_map: assert property (
		pslverr == (psel && penable && (paddr > 8'h18 || paddr[1:0] != 2'h0)))
		else $error("slave error mismatch");
endmodule : pbd_asserts
bind pbd_top pbd_asserts i_pbd_asserts (.pclk, .presetn, .clk_en, .manual_resetn, .psel,
	.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .portb_oe, .portb_pullup,
	.portb_periph_oe, .portb_periph_in, .portd_oe, .portd_pullup, .portd_periph_oe,
	.portd_periph_in);
`default_nettype wire

// [test/pbd_pins_model.sv]
`timescale 1ns/1ps
`default_nettype none
module pbd_pins_model #(parameter int N = 8) (
	input wire logic [N-1:0] oe,
	input wire logic [N-1:0] drv,
	input wire logic [N-1:0] pu_en,
	input wire logic [N-1:0] ext_en,
	input wire logic [N-1:0] ext,
	output logic [N-1:0] pin
);
	// Pin level from device drive, outside driver or pull-up
	assign pin = (oe & drv) | (~oe & ext_en & ext) | (~oe & ~ext_en & pu_en);
endmodule : pbd_pins_model
`default_nettype wire

// [test/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic pclk = 1'h0;
	logic presetn = 1'h0;
	logic manual_resetn = 1'h1;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [13:0] xe = 14'h0;
	logic [13:0] po = 14'h005a;
	logic [13:0] pe = 14'h000f;
	logic en = 1'h1;
	logic err = 1'h0;
	wire [31:0] prdata;
	wire pready, pslverr;
	wire [7:0] b_in, b_out, b_oe, b_pu, b_pi;
	wire [5:0] d_in, d_out, d_oe, d_pu, d_pi;
	int fails = 0, comparisons = 0, cyc = 0;
	always #50 pclk = ~pclk;
	pbd_top i_pbd_top (.pclk, .presetn, .clk_en(en), .manual_resetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .pstrb(4'hf), .prdata, .pready, .pslverr,
		.portb_in(b_in), .portb_out(b_out), .portb_oe(b_oe), .portb_pullup(b_pu),
		.portb_periph_out(po[7:0]), .portb_periph_oe(pe[7:0]), .portb_periph_in(b_pi),
		.portd_in(d_in), .portd_out(d_out), .portd_oe(d_oe), .portd_pullup(d_pu),
		.portd_periph_out(po[13:8]), .portd_periph_oe(pe[13:8]), .portd_periph_in(d_pi));
	pbd_pins_model #(.N(14)) i_pbd_pins_model (.oe({d_oe, b_oe}), .drv({d_out, b_out}),
		.pu_en({d_pu, b_pu}), .ext_en(xe), .ext(14'h003c), .pin({d_in, b_in}));
	// ----------------------------------------
	// Bus tasks and checks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e)
		begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		while (pready !== 1'h1)
			@(posedge pclk);
		err = pslverr;
		r = prdata;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	task automatic t_reset();
		logic [31:0] r;
		apb(1'h0, 8'h00, 32'h0, r);
		chk("pb_ctrl", r, 32'h000a);
		apb(1'h0, 8'h04, 32'h0, r);
		chk("pd_ctrl", r, 32'h0);
		chk("pb_pu", b_pu, 8'h03);
		chk("pb_oe", b_oe, 8'h0c);
		apb(1'h0, 8'h10, 32'h0, r);
		chk("pb_pins", r[1:0], 2'h3);
		chk("pb_periph_in", b_pi, 8'h08);
		$display("t_reset done");
	endtask : t_reset
	task automatic t_modes();
		logic [31:0] r;
		apb(1'h1, 8'h08, 32'ha5, r);
		for (int c = 0; c < 4; c++)
		begin
			apb(1'h1, 8'h00, 32'h5555 * c, r);
			xe <= (c == 3) ? 14'h3fff : 14'h0;
			apb(1'h0, 8'h00, 32'h0, r);
			chk("mode_rb", r, 32'h5555 * c);
			chk("pb_oe", b_oe, (c == 1) ? 8'hff : (c == 0) ? 8'h0f : 8'h00);
			chk("pb_pu", b_pu, (c == 2) ? 8'hff : 8'h00);
			if (c < 2)
				chk("pb_out", b_out, c ? 8'ha5 : 8'h5a);
			repeat (4) @(posedge pclk);
			apb(1'h0, 8'h10, 32'h0, r);
			if (c > 1)
				chk("pb_pins", r[7:0], (c == 3) ? 8'h3c : 8'hff);
		end
		$display("t_modes done");
	endtask : t_modes
	task automatic t_portd();
		logic [31:0] r;
		pe <= 14'h0;
		apb(1'h1, 8'h0c, 32'h2b, r);
		apb(1'h1, 8'h04, 32'h0801, r);
		apb(1'h0, 8'h04, 32'h0, r);
		chk("pd_ctrl", r, 32'h0801);
		chk("pd_pu", d_pu, 6'h20);
		chk("pd_oe", d_oe, 6'h01);
		chk("pd_out", d_out, 6'h01);
		chk("pd_periph_in", d_pi, 6'h00);
		$display("t_portd done");
	endtask : t_portd
	task automatic t_manual();
		logic [31:0] r;
		apb(1'h1, 8'h00, 32'h1b2d, r);
		manual_resetn <= 1'h0;
		repeat (8) @(posedge pclk);
		apb(1'h0, 8'h00, 32'h0, r);
		chk("pb_hold", r, 32'h1b2d);
		apb(1'h0, 8'h04, 32'h0, r);
		chk("pd_hold", r, 32'h0801);
		apb(1'h0, 8'h18, 32'h0, r);
		chk("mres_status", r, 32'h1);
		manual_resetn <= 1'h1;
		presetn <= 1'h0;
		repeat (3) @(posedge pclk);
		presetn <= 1'h1;
		apb(1'h0, 8'h00, 32'h0, r);
		chk("pb_por", r, 32'h000a);
		apb(1'h0, 8'h18, 32'h0, r);
		chk("mres_idle", r, 32'h0);
		$display("t_manual done");
	endtask : t_manual
	task automatic t_bus();
		logic [31:0] r;
		en <= 1'h0;
		apb(1'h1, 8'h00, 32'h5555, r);
		en <= 1'h1;
		apb(1'h0, 8'h00, 32'h0, r);
		chk("frozen", r, 32'h000a);
		chk("pslverr_ok", err, 1'h0);
		apb(1'h0, 8'h1c, 32'h0, r);
		chk("pslverr_bad", err, 1'h1);
		chk("unmapped", r, 32'h0);
		$display("t_bus done");
	endtask : t_bus
	task automatic print_verdict();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : print_verdict
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			fails++;
			print_verdict();
		end
	end
	initial
	begin
		repeat (12) @(posedge pclk);
		presetn <= 1'h1;
		t_reset();
		t_modes();
		t_portd();
		t_manual();
		t_bus();
		print_verdict();
	end
endmodule : testbench
`default_nettype wire
